// File: hdl/alp_pkg.sv
// package for the async list pointer register bank
package alp_pkg;
   localparam logic [7:0] ALP_OFS_CTRL_HEAD = 8'h20;
   localparam logic [7:0] ALP_OFS_CTRL_CUR = 8'h24;
   localparam logic [7:0] ALP_OFS_BULK_HEAD = 8'h28;
   localparam logic [7:0] ALP_OFS_BULK_CUR = 8'h2c;
   localparam int ALP_ADDR_LSB = 4;
   localparam logic [27:0] ALP_PTR_RST = 28'h0000000;
   localparam logic [3:0] ALP_RSVD_VAL = 4'h0;
   localparam int ALP_CLF_BIT = 1;
   localparam int ALP_BLF_BIT = 2;
   localparam int ALP_CLE_BIT = 4;
   localparam int ALP_BLE_BIT = 5;

   // register access from the memory window decoder
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] wdata;
   } alp_reg_req_t;

   // list engine events
   typedef struct packed {
      logic ctrl_served;
      logic [27:0] ctrl_next;
      logic ctrl_end;
      logic bulk_served;
      logic [27:0] bulk_next;
      logic bulk_end;
      logic shared_host_comm_area_load;
      logic [27:0] shared_host_comm_area_bulk_head;
   } alp_list_evt_t;
endpackage

// File: hdl/alp_regs.sv
// list pointer registers: control current, bulk head, bulk current
`timescale 1ns/1ns
module alp_regs (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire alp_pkg::alp_reg_req_t req_i,
   input wire alp_pkg::alp_list_evt_t evt_i,
   input wire logic [31:0] control_reg_i,
   input wire logic [31:0] command_status_reg_i,
   input wire logic [27:0] ctrl_head_addr_i,
   output logic [31:0] rdata_o,
   output logic clear_ctrl_filled_o,
   output logic clear_bulk_filled_o,
   output logic [31:0] ctrl_fetch_addr_o,
   output logic [31:0] bulk_fetch_addr_o
);
   import alp_pkg::*;

   logic [27:0] ctrl_current_addr;
   logic [27:0] bulk_head_addr;
   logic [27:0] bulk_current_addr;
   logic [27:0] next_ctrl_current_addr;
   logic [27:0] next_bulk_head_addr;
   logic [27:0] next_bulk_current_addr;
   logic [31:0] next_rdata;
   logic control_list_filled;
   logic bulk_list_filled;
   logic control_list_enable;
   logic bulk_list_enable;
   logic wr_ctrl_cur;
   logic wr_bulk_head;
   logic wr_bulk_cur;
   logic [27:0] wr_ptr;

   assign control_list_filled = command_status_reg_i[ALP_CLF_BIT];
   assign bulk_list_filled = command_status_reg_i[ALP_BLF_BIT];
   assign control_list_enable = control_reg_i[ALP_CLE_BIT];
   assign bulk_list_enable = control_reg_i[ALP_BLE_BIT];

   // ----------------------------------------------------------------
   // software write decode
   // ----------------------------------------------------------------
   // decoded for the checks below; the update logic decodes the same hits again in its own case statement
   assign wr_ctrl_cur = req_i.wr && (req_i.addr == ALP_OFS_CTRL_CUR);
   assign wr_bulk_head = req_i.wr && (req_i.addr == ALP_OFS_BULK_HEAD);
   assign wr_bulk_cur = req_i.wr && (req_i.addr == ALP_OFS_BULK_CUR);
   assign wr_ptr = req_i.wdata[31:ALP_ADDR_LSB];

   // ----------------------------------------------------------------
   // pointer update
   // ----------------------------------------------------------------
   // list engine wins over software; software writes to the current pointers
   // while the list runs are ignored so the engine never sees a torn pointer
   always_comb begin
      next_ctrl_current_addr = ctrl_current_addr;
      next_bulk_head_addr = bulk_head_addr;
      next_bulk_current_addr = bulk_current_addr;
      clear_ctrl_filled_o = 1'b0;
      clear_bulk_filled_o = 1'b0;
      if (req_i.wr) begin
         case (req_i.addr)
            ALP_OFS_CTRL_CUR: begin
               if (!control_list_enable) begin
                  next_ctrl_current_addr = req_i.wdata[31:ALP_ADDR_LSB];
               end
            end
            ALP_OFS_BULK_HEAD: begin
               next_bulk_head_addr = req_i.wdata[31:ALP_ADDR_LSB];
            end
            ALP_OFS_BULK_CUR: begin
               if (!bulk_list_enable) begin
                  next_bulk_current_addr = req_i.wdata[31:ALP_ADDR_LSB];
               end
            end
            default: begin
            end
         endcase
      end
      if (evt_i.shared_host_comm_area_load) begin
         next_bulk_head_addr = evt_i.shared_host_comm_area_bulk_head;
      end
      if (evt_i.ctrl_end) begin
         if (control_list_filled) begin
            next_ctrl_current_addr = ctrl_head_addr_i;
            clear_ctrl_filled_o = 1'b1;
         end
      end else if (evt_i.ctrl_served) begin
         next_ctrl_current_addr = evt_i.ctrl_next;
      end
      if (evt_i.bulk_end) begin
         if (bulk_list_filled) begin
            next_bulk_current_addr = next_bulk_head_addr;
            clear_bulk_filled_o = 1'b1;
         end
      end else if (evt_i.bulk_served) begin
         // the engine follows insertion order, giving round robin
         next_bulk_current_addr = evt_i.bulk_next;
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      case (req_i.addr)
         ALP_OFS_CTRL_CUR: next_rdata = {ctrl_current_addr, ALP_RSVD_VAL};
         ALP_OFS_BULK_HEAD: next_rdata = {bulk_head_addr, ALP_RSVD_VAL};
         ALP_OFS_BULK_CUR: next_rdata = {bulk_current_addr, ALP_RSVD_VAL};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= 32'h00000000;
      end else begin
         rdata_o <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // pointer registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_current_addr <= ALP_PTR_RST;
         bulk_head_addr <= ALP_PTR_RST;
         bulk_current_addr <= ALP_PTR_RST;
      end else begin
         ctrl_current_addr <= next_ctrl_current_addr;
         bulk_head_addr <= next_bulk_head_addr;
         bulk_current_addr <= next_bulk_current_addr;
      end
   end

   // the engine fetches from the current pointer each frame
   assign ctrl_fetch_addr_o = {ctrl_current_addr, ALP_RSVD_VAL};
   assign bulk_fetch_addr_o = {bulk_current_addr, ALP_RSVD_VAL};

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   AST_CTRL_ADVANCE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.ctrl_served && !evt_i.ctrl_end |=> ctrl_current_addr == $past(evt_i.ctrl_next))
      else $error("control pointer did not advance");
   AST_CTRL_NOFLAG: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.ctrl_end && !control_list_filled && !req_i.wr |=> $stable(ctrl_current_addr))
      else $error("control pointer moved without filled flag");
   AST_CTRL_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.ctrl_end && control_list_filled |-> clear_ctrl_filled_o
      ##1 ctrl_current_addr == $past(ctrl_head_addr_i))
      else $error("control wrap failed");
   AST_CTRL_WR_LOCK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.wr && req_i.addr == ALP_OFS_CTRL_CUR && control_list_enable
      && !evt_i.ctrl_end && !evt_i.ctrl_served |=> $stable(ctrl_current_addr))
      else $error("control pointer written while enabled");
   AST_BULK_WR_LOCK: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.wr && req_i.addr == ALP_OFS_BULK_CUR && bulk_list_enable
      && !evt_i.bulk_end && !evt_i.bulk_served |=> $stable(bulk_current_addr))
      else $error("bulk pointer written while enabled");
   AST_BULK_WRAP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && bulk_list_filled && !evt_i.shared_host_comm_area_load
      && !(req_i.wr && req_i.addr == ALP_OFS_BULK_HEAD)
      |=> bulk_current_addr == $past(bulk_head_addr))
      else $error("bulk wrap failed");
   AST_SHARED_HOST_COMM_AREA_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.shared_host_comm_area_load |=> bulk_head_addr == $past(evt_i.shared_host_comm_area_bulk_head))
      else $error("bulk head not loaded");
   AST_BULK_ADV: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_served && !evt_i.bulk_end |=> bulk_current_addr == $past(evt_i.bulk_next))
      else $error("bulk pointer did not advance");
   AST_RSVD_ZERO: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      rdata_o[3:0] == ALP_RSVD_VAL && ctrl_fetch_addr_o[3:0] == ALP_RSVD_VAL)
      else $error("reserved bits not zero");
   AST_RD_BULK_HEAD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.addr == ALP_OFS_BULK_HEAD |=> rdata_o == {$past(bulk_head_addr), ALP_RSVD_VAL})
      else $error("bulk head read wrong");

   // ----------------------------------------------------------------
   // assertions: software access
   // ----------------------------------------------------------------
   // software writes only count on quiet cycles, since engine events win
   AST_CTRL_WR_OPEN: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      wr_ctrl_cur && !control_list_enable && !evt_i.ctrl_end && !evt_i.ctrl_served
      |=> ctrl_current_addr == $past(wr_ptr))
      else $error("control pointer write lost");

   AST_BULK_WR_OPEN: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      wr_bulk_cur && !bulk_list_enable && !evt_i.bulk_end && !evt_i.bulk_served
      |=> bulk_current_addr == $past(wr_ptr))
      else $error("bulk pointer write lost");

   AST_BULK_HEAD_WR: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      wr_bulk_head && !evt_i.shared_host_comm_area_load
      |=> bulk_head_addr == $past(wr_ptr))
      else $error("bulk head write lost");

   AST_RD_CTRL_CUR: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.addr == ALP_OFS_CTRL_CUR
      |=> rdata_o == {$past(ctrl_current_addr), ALP_RSVD_VAL})
      else $error("control pointer read wrong");

   AST_RD_BULK_CUR: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.addr == ALP_OFS_BULK_CUR
      |=> rdata_o == {$past(bulk_current_addr), ALP_RSVD_VAL})
      else $error("bulk pointer read wrong");

   AST_RD_UNMAPPED: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.addr != ALP_OFS_CTRL_CUR && req_i.addr != ALP_OFS_BULK_HEAD
      && req_i.addr != ALP_OFS_BULK_CUR
      |=> rdata_o == 32'h00000000)
      else $error("unmapped read not zero");

   AST_WR_UNMAPPED: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.wr && !wr_ctrl_cur && !wr_bulk_head && !wr_bulk_cur && evt_i == '0
      |=> $stable(ctrl_current_addr) && $stable(bulk_head_addr) && $stable(bulk_current_addr))
      else $error("unmapped write changed a pointer");

   // ----------------------------------------------------------------
   // assertions: list engine
   // ----------------------------------------------------------------
   AST_CTRL_HOLD: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      !wr_ctrl_cur && !evt_i.ctrl_end && !evt_i.ctrl_served
      |=> $stable(ctrl_fetch_addr_o))
      else $error("control fetch address drifted");

   AST_BULK_HOLD: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      !wr_bulk_cur && !evt_i.bulk_end && !evt_i.bulk_served
      |=> $stable(bulk_fetch_addr_o))
      else $error("bulk fetch address drifted");

   AST_HEAD_HOLD: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      !wr_bulk_head && !evt_i.shared_host_comm_area_load
      |=> $stable(bulk_head_addr))
      else $error("bulk head drifted");

   AST_BULK_NOFLAG: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && !bulk_list_filled && !wr_bulk_cur
      |=> $stable(bulk_current_addr))
      else $error("bulk pointer moved without filled flag");

   AST_BULK_WRAP_CLR: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && bulk_list_filled
      |-> clear_bulk_filled_o)
      else $error("bulk filled flag not cleared");

   AST_CLR_CTRL_CAUSE: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      clear_ctrl_filled_o
      |-> evt_i.ctrl_end && control_list_filled)
      else $error("control filled flag cleared without cause");

   AST_CLR_BULK_CAUSE: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      clear_bulk_filled_o
      |-> evt_i.bulk_end && bulk_list_filled)
      else $error("bulk filled flag cleared without cause");

   // the wrap copies the head as it stands after this cycle's load or write
   AST_SHARED_HOST_COMM_AREA_WRAP: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && bulk_list_filled && evt_i.shared_host_comm_area_load
      |=> bulk_current_addr == $past(evt_i.shared_host_comm_area_bulk_head))
      else $error("bulk wrap missed loaded head");

   AST_WRAP_HEAD_WR: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && bulk_list_filled && wr_bulk_head && !evt_i.shared_host_comm_area_load
      |=> bulk_current_addr == $past(wr_ptr))
      else $error("bulk wrap missed written head");

   AST_SERVED_NO_CLR: assert property (
      @(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.ctrl_served && !evt_i.ctrl_end
      |-> !clear_ctrl_filled_o)
      else $error("control filled flag cleared on advance");

   // ----------------------------------------------------------------
   // cover points
   // ----------------------------------------------------------------

   COV_CTRL_WRAP: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.ctrl_end && control_list_filled);
   COV_BULK_WRAP: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && bulk_list_filled);
   COV_LOCKED_WR: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      req_i.wr && req_i.addr == ALP_OFS_CTRL_CUR && control_list_enable);
   COV_SHARED_HOST_COMM_AREA_WRAP: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      evt_i.bulk_end && bulk_list_filled && evt_i.shared_host_comm_area_load);
   COV_BULK_LOCKED_WR: cover property (@(posedge sys_clk_i) disable iff (!rstn_i)
      wr_bulk_cur && bulk_list_enable);
endmodule

// File: test/alp_regs_tb.sv
// self-checking testbench for the list pointer register bank
`timescale 1ns/1ns
module testbench;
   import alp_pkg::*;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   alp_reg_req_t req = '0;
   alp_list_evt_t evt = '0;
   alp_list_evt_t e;
   logic [31:0] ctl = '0;
   logic [31:0] sts = '0;
   logic [27:0] chead = '0;
   logic [31:0] rdata;
   logic [31:0] cfa;
   logic [31:0] bfa;
   logic clr_c;
   logic clr_b;
   logic [27:0] m_cc = '0;
   logic [27:0] m_bh = '0;
   logic [27:0] m_bc = '0;
   integer seed = 77;
   int bad_count = 0;
   int checks = 0;
   always #2 sys_clk_i = ~sys_clk_i;
   alp_regs u_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .req_i(req), .evt_i(evt),
      .control_reg_i(ctl), .command_status_reg_i(sts), .ctrl_head_addr_i(chead),
      .rdata_o(rdata), .clear_ctrl_filled_o(clr_c), .clear_bulk_filled_o(clr_b),
      .ctrl_fetch_addr_o(cfa), .bulk_fetch_addr_o(bfa));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] word(input logic [27:0] p);
      return {p, ALP_RSVD_VAL};
   endfunction
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // software keeps reserved bits zero; the model mirrors the enable gating
   // each task drops the strobes of the one before, so none is set twice at once
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      evt = '0;
      req = '{wr: 1'b1, addr: a, wdata: d & 32'hffff_fff0};
      if (a == ALP_OFS_CTRL_CUR && !ctl[ALP_CLE_BIT]) m_cc = d[31:4];
      if (a == ALP_OFS_BULK_HEAD) m_bh = d[31:4];
      if (a == ALP_OFS_BULK_CUR && !ctl[ALP_BLE_BIT]) m_bc = d[31:4];
      @(negedge sys_clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      evt = '0;
      req = '{wr: 1'b0, addr: a, wdata: 32'h00000000};
      @(negedge sys_clk_i);
      chk("rdata", rdata, exp);
   endtask
   // clear outputs are combinational, so they are sampled before the edge
   task automatic go(input alp_list_evt_t ev);
      req.wr = 1'b0;
      evt = ev;
      #1;
      chk("clear_ctrl", 32'(clr_c), 32'(ev.ctrl_end & sts[ALP_CLF_BIT]));
      chk("clear_bulk", 32'(clr_b), 32'(ev.bulk_end & sts[ALP_BLF_BIT]));
      @(negedge sys_clk_i);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      rd(ALP_OFS_CTRL_CUR, 32'h0);
      rd(ALP_OFS_BULK_CUR, 32'h0);
      wr(8'h30, 32'hffff_fff0);
      rd(8'h30, 32'h0);
      for (int i = 0; i < 16; i++) begin
         ctl = (i < 2) ? 32'h0 : ((i < 4) ? 32'h30 : $random(seed));
         sts = (i < 2) ? 32'h0 : ((i < 4) ? 32'h6 : $random(seed));
         chead = 28'($random(seed));
         wr(ALP_OFS_CTRL_CUR, $random(seed));
         wr(ALP_OFS_BULK_HEAD, $random(seed));
         wr(ALP_OFS_BULK_CUR, $random(seed));
         rd(ALP_OFS_CTRL_CUR, word(m_cc));
         rd(ALP_OFS_BULK_HEAD, word(m_bh));
         rd(ALP_OFS_BULK_CUR, word(m_bc));
         e = '0;
         e.ctrl_served = 1'b1;
         e.ctrl_next = 28'($random(seed));
         e.bulk_served = 1'b1;
         e.bulk_next = 28'($random(seed));
         go(e);
         m_cc = e.ctrl_next;
         m_bc = e.bulk_next;
         chk("ctrl_fetch", cfa, word(m_cc));
         chk("bulk_fetch", bfa, word(m_bc));
         e = '0;
         e.shared_host_comm_area_load = 1'b1;
         e.shared_host_comm_area_bulk_head = 28'($random(seed));
         e.bulk_end = i[0];
         go(e);
         m_bh = e.shared_host_comm_area_bulk_head;
         if (e.bulk_end && sts[ALP_BLF_BIT]) m_bc = m_bh;
         chk("bulk_fetch", bfa, word(m_bc));
         rd(ALP_OFS_BULK_HEAD, word(m_bh));
         e = '0;
         e.ctrl_end = 1'b1;
         e.bulk_end = 1'b1;
         go(e);
         if (sts[ALP_CLF_BIT]) m_cc = chead;
         if (sts[ALP_BLF_BIT]) m_bc = m_bh;
         chk("ctrl_fetch", cfa, word(m_cc));
         chk("bulk_fetch", bfa, word(m_bc));
         rd(ALP_OFS_CTRL_CUR, word(m_cc));
      end
      // a reset in mid-run must clear every pointer again
      rstn_i = 1'b0;
      repeat (2) @(negedge sys_clk_i);
      rstn_i = 1'b1;
      chk("ctrl_fetch", cfa, 32'h0);
      chk("bulk_fetch", bfa, 32'h0);
      rd(ALP_OFS_BULK_HEAD, 32'h0);
      rd(ALP_OFS_CTRL_CUR, 32'h0);
      rd(ALP_OFS_BULK_CUR, 32'h0);
      finish_test();
   end
   // the loop needs well under a thousand cycles
   initial begin
      #20000;
      bad_count++;
      finish_test();
   end
endmodule
